// ### shared/tcp_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// timer array constants
// ----------------------------------------------------------------
package tcp_pkg;
    localparam int NCH = 8;
    localparam int CW  = 16;
    localparam int AW  = 8;

    typedef logic [CW-1:0] tcp_cnt_t;
    typedef logic [1:0]    tcp_mode_t;

    // channel modes, two bits per channel in the mode register
    localparam tcp_mode_t MODE_CAPT    = 2'h0;
    localparam tcp_mode_t MODE_ONESHOT = 2'h1;
    localparam tcp_mode_t MODE_PWM     = 2'h2;
    localparam tcp_mode_t MODE_OFF     = 2'h3;

    localparam tcp_cnt_t CNT_ZERO = 16'h0000;
    localparam tcp_cnt_t CNT_ONE  = 16'h0001;
    localparam tcp_cnt_t CNT_MAX  = 16'hffff;

    // only even channels may lead a group
    localparam logic [NCH-1:0] EVEN_MASK = 8'h55;

    // register byte offsets
    localparam logic [AW-1:0] OFF_START    = 8'h00;
    localparam logic [AW-1:0] OFF_STOP     = 8'h04;
    localparam logic [AW-1:0] OFF_RUN      = 8'h08;
    localparam logic [AW-1:0] OFF_MODE     = 8'h0c;
    localparam logic [AW-1:0] OFF_MASTER   = 8'h10;
    localparam logic [AW-1:0] OFF_OVF      = 8'h14;
    localparam logic [AW-1:0] OFF_IRQ_ST   = 8'h18;
    localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h1c;
    localparam logic [AW-1:0] OFF_DATA     = 8'h40;

    localparam logic [2*NCH-1:0] MODE_RST   = 16'hffff;
    localparam logic [NCH-1:0]   MASTER_RST = 8'h00;
    localparam logic [NCH-1:0]   MASK_RST   = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### shared/tcp_ch_if.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// control side to one channel counter
// ----------------------------------------------------------------
interface tcp_ch_if;
    import tcp_pkg::*;
    tcp_mode_t mode;
    logic      master;
    logic      run;
    tcp_cnt_t  preset;
    logic      tin_edge;
    logic      sync;
    logic      cap_stb;
    tcp_cnt_t  cap_val;
    logic      ovf;
    logic      tout;
    logic      evt;
    logic      tick;

    modport ctl (output mode, master, run, preset, tin_edge, sync,
                 input cap_stb, cap_val, ovf, tout, evt, tick);
    modport chan (input mode, master, run, preset, tin_edge, sync,
                  output cap_stb, cap_val, ovf, tout, evt, tick);
endinterface
`default_nettype wire

// ### rtl/tcp_chan.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// one 16-bit timer channel
// ----------------------------------------------------------------
module tcp_chan
    import tcp_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    tcp_ch_if.chan    ch
);
    typedef enum {CH_IDLE, CH_COUNT} tcp_ch_st_e;

    tcp_ch_st_e st_ff;
    tcp_cnt_t   cnt_ff;
    tcp_cnt_t   cap_val_ff;
    logic       run_d_ff;
    logic       wrap_ff;
    logic       cap_stb_ff;
    logic       ovf_ff;
    logic       tout_ff;
    logic       evt_ff;
    logic       tick_ff;
    logic       hit;
    logic       start;
    logic       capt;

    assign hit   = (cnt_ff == ch.preset);
    assign start = ch.run & ~run_d_ff;
    assign capt  = ch.run & (ch.mode == MODE_CAPT);

    // counting, pulse shaping and events; stopping clears the counter
    always_ff @(posedge aclk) begin
        if (!aresetn || !ch.run) begin
            st_ff   <= CH_IDLE;
            cnt_ff  <= CNT_ZERO;
            tout_ff <= 1'b0;
            tick_ff <= 1'b0;
            evt_ff  <= 1'b0;
        end else begin
            tick_ff <= 1'b0;
            evt_ff  <= 1'b0;
            if (ch.mode == MODE_CAPT) begin
                cnt_ff <= ch.tin_edge ? CNT_ZERO : cnt_ff + CNT_ONE; // [RQ1]
                evt_ff <= ch.tin_edge; // [RQ1]
            end else if (ch.mode == MODE_PWM && ch.master) begin
                // period is preset+1 clocks; a preset lowered below the count wraps once
                if (start || hit) begin
                    cnt_ff  <= CNT_ZERO; // [RQ7]
                    tick_ff <= 1'b1; // [RQ8]
                    evt_ff  <= 1'b1; // [RQ8]
                end else begin
                    cnt_ff <= cnt_ff + CNT_ONE;
                end
            end else if (ch.mode != MODE_OFF) begin
                case (st_ff)
                    CH_IDLE: begin
                        if (ch.master && ch.tin_edge) begin
                            st_ff  <= CH_COUNT; // [RQ4]
                            cnt_ff <= CNT_ZERO;
                        end else if (!ch.master && ch.sync) begin
                            cnt_ff  <= CNT_ONE;
                            tout_ff <= (ch.preset != CNT_ZERO); // [RQ10]
                            st_ff   <= (ch.preset != CNT_ZERO) ? CH_COUNT : CH_IDLE;
                        end
                    end
                    CH_COUNT: begin
                        if (!ch.master && ch.sync) begin
                            cnt_ff  <= CNT_ONE; // [RQ10]
                            tout_ff <= (ch.preset != CNT_ZERO);
                        end else if (hit) begin
                            st_ff   <= CH_IDLE;
                            tout_ff <= 1'b0; // [RQ10]
                            tick_ff <= ch.master; // [RQ3]
                            evt_ff  <= 1'b1; // [RQ4]
                        end else begin
                            cnt_ff <= cnt_ff + CNT_ONE;
                        end
                    end
                    default: st_ff <= CH_IDLE;
                endcase
            end
        end
    end

    // capture and overflow tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_d_ff   <= 1'b0;
            wrap_ff    <= 1'b0;
            ovf_ff     <= 1'b0;
            cap_stb_ff <= 1'b0;
            cap_val_ff <= CNT_ZERO;
        end else begin
            run_d_ff   <= ch.run;
            cap_stb_ff <= capt & ch.tin_edge; // [RQ1]
            if (capt && ch.tin_edge) begin
                cap_val_ff <= cnt_ff; // [RQ1]
                ovf_ff     <= wrap_ff; // [RQ9]
                wrap_ff    <= 1'b0;
            end else if (capt && cnt_ff == CNT_MAX) begin
                wrap_ff <= 1'b1; // [RQ9]
            end
        end
    end

    assign ch.cap_stb = cap_stb_ff;
    assign ch.cap_val = cap_val_ff;
    assign ch.ovf     = ovf_ff;
    assign ch.tout    = tout_ff;
    assign ch.evt     = evt_ff;
    assign ch.tick    = tick_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence os_arm;
        ch.run && ch.master && ch.mode == MODE_ONESHOT && st_ff == CH_IDLE && ch.tin_edge;
    endsequence
    sequence os_fire;
        ch.run && ch.master && ch.mode == MODE_ONESHOT && st_ff == CH_COUNT && hit;
    endsequence

    ovf_track_a: assert property (capt && ch.tin_edge |=> ch.ovf == $past(wrap_ff)) // [RQ9]
        else $error("overflow flag does not follow wrap");
    os_arm_a: assert property (os_arm |=> st_ff == CH_COUNT && cnt_ff == CNT_ZERO) // [RQ4]
        else $error("one-shot trigger not taken");
    os_fire_a: assert property (os_fire |=> ch.tick && ch.evt && st_ff == CH_IDLE) // [RQ3]
        else $error("one-shot delay end missed");
    pulse_end_a: assert property (ch.run && !ch.master && ch.mode == MODE_PWM && st_ff == CH_COUNT // [RQ10]
                                  && hit && !ch.sync |=> !ch.tout && ch.evt)
        else $error("duty match did not end pulse");
endmodule
`default_nettype wire

// ### rtl/tcp_top.sv
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RQ1: an interval channel stores its running count in its data register on each input edge and interrupts.
// RQ2: writing a start bit starts that channel and its running flag reads set while it operates.
// RQ3: a one-shot pairs a master whose data sets the delay with a slave whose data sets the width.
// RQ4: a one-shot starts on an edge at the master input, the pulse leaves the slave pin, both interrupt.
// RQ5: only even channels can be masters; odd channels are slaves only.
// RQ6: a slave's number is above its master's and at most the last channel.
// RQ7: in PWM the master data sets the period, the slave data the duty, output on the slave pin.
// RQ8: in multiple PWM one master gives a common period to several slaves, each with its own duty.
// RQ9: the overflow flag sets if the count wraps before a capture and clears on a capture without wrap.
// RQ10: a PWM slave output goes active at each period start and inactive when its count meets the duty.
module tcp_top
    import tcp_pkg::*;
(
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [AW-1:0]   awaddr,
    input  wire logic            wvalid,
    output logic                 wready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    output logic                 bvalid,
    input  wire logic            bready,
    output logic [1:0]           bresp,
    input  wire logic            arvalid,
    output logic                 arready,
    input  wire logic [AW-1:0]   araddr,
    output logic                 rvalid,
    input  wire logic            rready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    input  wire logic [NCH-1:0]  timer_input_pin,
    output logic [NCH-1:0]       timer_output_pin,
    output logic [NCH-1:0]       channel_interrupt,
    output logic                 irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    tcp_cnt_t          data_ff [NCH];
    logic [NCH-1:0]    run_ff;
    logic [2*NCH-1:0]  mode_ff;
    logic [NCH-1:0]    master_ff;
    logic [NCH-1:0]    irq_st_ff;
    logic [NCH-1:0]    irq_mask_ff;
    logic              irq_ff;
    logic [NCH-1:0]    tin_s1_ff;
    logic [NCH-1:0]    tin_s2_ff;
    logic [NCH-1:0]    tin_s3_ff;
    logic              aw_hold_ff;
    logic              w_hold_ff;
    logic [AW-1:0]     wr_addr_ff;
    logic [31:0]       wr_data_ff;
    logic [3:0]        wr_strb_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              rvalid_ff;
    logic [31:0]       rdata_ff;
    logic [1:0]        rresp_ff;

    logic [NCH-1:0]    master_eff;
    logic [NCH-1:0]    own_vld;
    logic [2:0]        own_idx [NCH];
    logic [NCH-1:0]    tick;
    logic [NCH-1:0]    evt;
    logic [NCH-1:0]    cap_stb;
    logic [NCH-1:0]    ovf;
    logic [NCH-1:0]    tout;
    tcp_cnt_t          cap_val [NCH];
    logic              wr_do;
    logic              ar_fire;
    logic              rd_clr;
    logic              wr_hit;
    logic [31:0]       rd_val;
    logic              rd_hit;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_data(input logic [AW-1:0] a);
        return a[AW-1:5] == OFF_DATA[AW-1:5];
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------------------------------
    // pins are asynchronous; the edge compares stages two and three only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tin_s1_ff <= '0;
            tin_s2_ff <= '0;
            tin_s3_ff <= '0;
        end else begin
            tin_s1_ff <= timer_input_pin;
            tin_s2_ff <= tin_s1_ff;
            tin_s3_ff <= tin_s2_ff;
        end
    end

    // ----------------------------------------------------------------
    // master and slave grouping
    // ----------------------------------------------------------------
    assign master_eff = master_ff & EVEN_MASK; // [RQ5]

    // each slave follows the nearest enabled master below it
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            own_vld[i] = 1'b0;
            own_idx[i] = 3'h0;
            for (int j = 0; j < i; j += 2) begin
                if (master_eff[j]) begin
                    own_vld[i] = 1'b1; // [RQ6]
                    own_idx[i] = 3'(j);
                end
            end
            if (master_eff[i]) begin
                own_vld[i] = 1'b0; // [RQ5]
            end
        end
    end

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    tcp_ch_if ch [NCH] ();

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign ch[g].mode     = mode_ff[2*g +: 2];
        assign ch[g].master   = master_eff[g];
        assign ch[g].run      = run_ff[g];
        assign ch[g].preset   = data_ff[g]; // [RQ7]
        assign ch[g].tin_edge = tin_s2_ff[g] & ~tin_s3_ff[g];
        assign ch[g].sync     = own_vld[g] & tick[own_idx[g]]; // [RQ8]
        assign tick[g]        = ch[g].tick;
        assign evt[g]         = ch[g].evt;
        assign cap_stb[g]     = ch[g].cap_stb;
        assign cap_val[g]     = ch[g].cap_val;
        assign ovf[g]         = ch[g].ovf;
        assign tout[g]        = ch[g].tout;

        tcp_chan u_chan (
            .aclk    (aclk),
            .aresetn (aresetn),
            .ch      (ch[g])
        );
    end

    assign timer_output_pin  = tout; // [RQ4]
    assign channel_interrupt = evt;

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    assign awready = ~aw_hold_ff;
    assign wready  = ~w_hold_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign wr_do   = aw_hold_ff & w_hold_ff & ~bvalid_ff;

    assign wr_hit = is_data(wr_addr_ff)
                  || wr_addr_ff == OFF_START || wr_addr_ff == OFF_STOP
                  || wr_addr_ff == OFF_MODE || wr_addr_ff == OFF_MASTER
                  || wr_addr_ff == OFF_IRQ_MASK;

    // address and data latch independently, the write runs once both are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            wr_addr_ff <= '0;
            wr_data_ff <= '0;
            wr_strb_ff <= '0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            if (awvalid && !aw_hold_ff) begin
                aw_hold_ff <= 1'b1;
                wr_addr_ff <= awaddr;
            end
            if (wvalid && !w_hold_ff) begin
                w_hold_ff  <= 1'b1;
                wr_data_ff <= wdata;
                wr_strb_ff <= wstrb;
            end
            if (wr_do) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    // start sets, stop clears; a start and a stop never share a write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_ff <= '0;
        end else if (wr_do && wr_addr_ff == OFF_START && wr_strb_ff[0]) begin
            run_ff <= run_ff | wr_data_ff[NCH-1:0]; // [RQ2]
        end else if (wr_do && wr_addr_ff == OFF_STOP && wr_strb_ff[0]) begin
            run_ff <= run_ff & ~wr_data_ff[NCH-1:0];
        end
    end

    // configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff     <= MODE_RST;
            master_ff   <= MASTER_RST;
            irq_mask_ff <= MASK_RST;
        end else if (wr_do) begin
            if (wr_addr_ff == OFF_MODE) begin
                mode_ff <= (2*NCH)'(merge({16'h0000, mode_ff}, wr_data_ff, wr_strb_ff));
            end
            if (wr_addr_ff == OFF_MASTER) begin
                master_ff <= NCH'(merge({24'h000000, master_ff}, wr_data_ff, wr_strb_ff));
            end
            if (wr_addr_ff == OFF_IRQ_MASK) begin
                irq_mask_ff <= NCH'(merge({24'h000000, irq_mask_ff}, wr_data_ff, wr_strb_ff));
            end
        end
    end

    // data registers; a capture beats a software write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NCH; i++) begin
                data_ff[i] <= CNT_ZERO;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (cap_stb[i]) begin
                    data_ff[i] <= cap_val[i]; // [RQ1]
                end else if (wr_do && is_data(wr_addr_ff) && wr_addr_ff[4:2] == 3'(i)) begin
                    data_ff[i] <= CW'(merge({16'h0000, data_ff[i]}, wr_data_ff, wr_strb_ff)); // [RQ3]
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    // sticky status, cleared by reading it; a new event in that cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st_ff <= '0;
            irq_ff    <= 1'b0;
        end else begin
            irq_st_ff <= (rd_clr ? '0 : irq_st_ff) | evt; // [RQ4]
            irq_ff    <= |(irq_st_ff & irq_mask_ff);
        end
    end

    assign irq = irq_ff;

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    assign arready = ~rvalid_ff;
    assign ar_fire = arvalid & ~rvalid_ff;
    assign rd_clr  = ar_fire && araddr == OFF_IRQ_ST;
    assign rvalid  = rvalid_ff;
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;

    // read mux; start and stop are write-only and read zero
    always_comb begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        if (is_data(araddr)) begin
            rd_val[CW-1:0] = data_ff[araddr[4:2]];
        end else begin
            case (araddr)
                OFF_START, OFF_STOP: rd_val = 32'h00000000;
                OFF_RUN:      rd_val[NCH-1:0] = run_ff; // [RQ2]
                OFF_MODE:     rd_val[2*NCH-1:0] = mode_ff;
                OFF_MASTER:   rd_val[NCH-1:0] = master_eff;
                OFF_OVF:      rd_val[NCH-1:0] = ovf; // [RQ9]
                OFF_IRQ_ST:   rd_val[NCH-1:0] = irq_st_ff;
                OFF_IRQ_MASK: rd_val[NCH-1:0] = irq_mask_ff;
                default:      rd_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_val;
            rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    cap_store_a: assert property (cap_stb[3] |=> data_ff[3] == $past(cap_val[3])) // [RQ1]
        else $error("capture not stored in data register");
    run_flag_a: assert property (wr_do && wr_addr_ff == OFF_START && wr_strb_ff[0] && wr_data_ff[1] // [RQ2]
                                 |=> run_ff[1] ##1 run_ff[1])
        else $error("start write did not set running flag");
    master_even_a: assert property (master_eff[1] == 1'b0 && master_eff[7] == 1'b0) // [RQ5]
        else $error("odd channel acting as master");
    slave_order_a: assert property (own_vld[7] |-> own_idx[7] < 3'h7 && master_eff[own_idx[7]]) // [RQ6]
        else $error("slave owned by invalid master");
    duty_rise_a: assert property (run_ff[1] && mode_ff[3:2] == MODE_PWM && own_vld[1] // [RQ7]
                                  && tick[0] && data_ff[1] != CNT_ZERO |=> timer_output_pin[1])
        else $error("pwm output not raised at period start");
    period_share_a: assert property (tick[0] && run_ff[1] && run_ff[2] && own_vld[1] && own_vld[2] // [RQ8]
                                     && mode_ff[3:2] == MODE_PWM && mode_ff[5:4] == MODE_PWM
                                     && data_ff[1] != CNT_ZERO && data_ff[2] != CNT_ZERO
                                     |=> timer_output_pin[1] && timer_output_pin[2])
        else $error("slaves of one master out of step");
    irq_sticky_a: assert property (evt[2] |=> irq_st_ff[2]) // [RQ4]
        else $error("event lost from status");
endmodule
`default_nettype wire

// ### verification/tcp_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// external pulse source on the input pins
// ----------------------------------------------------------------
module tcp_src_model (
    input  wire logic  aclk,
    output logic [7:0] pin
);
    initial pin = 8'h00;
    // edge held 4 cycles so the sync stages cannot miss it
    task automatic pulse(input int c);
        pin[c] <= 1'b1;
        repeat (4) @(posedge aclk);
        pin[c] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import tcp_pkg::*;
    logic           aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic           arvalid, arready, rvalid, rready, irq;
    logic [AW-1:0]  awaddr, araddr;
    logic [31:0]    wdata, rdata, v, u;
    logic [3:0]     wstrb;
    logic [1:0]     bresp, rresp, rr;
    logic [NCH-1:0] timer_input_pin, timer_output_pin, channel_interrupt;
    int             err_total, cmp_count, hi, per;
    tcp_top u_tcp_top (.*);
    tcp_src_model u_tcp_src_model (.aclk(aclk), .pin(timer_input_pin));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // handshakes judged at the rising edge itself, before that edge's updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw;
        ha = 1'b0; hw = 1'b0;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        while (!(ha && hw)) begin
            @(posedge aclk);
            if (!ha && awready) begin ha = 1'b1; awvalid <= 1'b0; end
            if (!hw && wready) begin hw = 1'b1; wvalid <= 1'b0; end
        end
        bready <= 1'b1;
        do begin @(posedge aclk); end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a; arvalid <= 1'b1;
        do begin @(posedge aclk); end while (!arready);
        arvalid <= 1'b0; rready <= 1'b1;
        do begin @(posedge aclk); end while (!rvalid);
        d = rdata; rr = rresp;
        rready <= 1'b0;
    endtask
    // high time and period of one output, in cycles
    task automatic meas(input int c);
        @(negedge aclk);
        while (timer_output_pin[c] !== 1'b0) @(negedge aclk);
        while (timer_output_pin[c] !== 1'b1) @(negedge aclk);
        hi = 0; per = 0;
        while (timer_output_pin[c] === 1'b1) begin hi++; per++; @(negedge aclk); end
        while (timer_output_pin[c] !== 1'b1) begin per++; @(negedge aclk); end
        @(posedge aclk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd(OFF_MODE, v); chk("mode_rst", v, 32'hffff);
        rd(8'h30, v); chk("bad_resp", {30'h0, rr}, 32'h2); chk("bad_data", v, 32'h0);
        wr(OFF_MASTER, 32'hff); rd(OFF_MASTER, v); chk("master", v, 32'h55);
    endtask
    // two channels started together, edges 10 cycles apart
    task automatic t_capture;
        wr(OFF_MODE, 32'hf33f); wr(OFF_MASTER, 32'h0); rd(OFF_IRQ_ST, v);
        wr(OFF_START, 32'h28); rd(OFF_RUN, v); chk("run", v, 32'h28);
        fork
            u_tcp_src_model.pulse(3);
            begin repeat (10) @(posedge aclk); u_tcp_src_model.pulse(5); end
        join
        repeat (5) @(posedge aclk);
        rd(8'h4c, v); rd(8'h54, u); chk("interval", u - v, 32'd10);
        rd(OFF_IRQ_ST, v); chk("cap_irq", v, 32'h28);
        rd(OFF_OVF, v); chk("ovf", v, 32'h0);
        wr(OFF_STOP, 32'h28); rd(OFF_RUN, v); chk("stop", v, 32'h0);
    endtask
    // master 0 preset 9 (period 10), slaves 1 and 2 with duties 3 and 5
    task automatic t_pwm;
        wr(OFF_MODE, 32'hffea); wr(OFF_MASTER, 32'h1); wr(8'h40, 32'd9);
        wr(8'h44, 32'd3); wr(8'h48, 32'd5); wr(OFF_IRQ_MASK, 32'h1); wr(OFF_START, 32'h7);
        meas(1); chk("duty1", 32'(hi), 32'd3); chk("period", 32'(per), 32'd10);
        meas(2); chk("duty2", 32'(hi), 32'd5); chk("period2", 32'(per), 32'd10);
        chk("irq_on", {31'h0, irq}, 32'h1);
        wr(OFF_IRQ_MASK, 32'h0); wr(OFF_STOP, 32'h7);
        rd(OFF_IRQ_ST, v); chk("pwm_irq", v, 32'h7);
        repeat (3) @(posedge aclk);
        chk("irq_off", {31'h0, irq}, 32'h0);
    endtask
    // master 0 (still flagged) delay 4, slave 1 width 3, fired by one edge on pin 0
    task automatic t_oneshot;
        int lo, n0, n1;
        lo = 0; n0 = 0; n1 = 0; hi = 0;
        wr(OFF_MODE, 32'hfff5); wr(8'h40, 32'd4); wr(8'h44, 32'd3); wr(OFF_START, 32'h3);
        fork
            u_tcp_src_model.pulse(0);
            repeat (30) begin
                @(negedge aclk);
                if (timer_output_pin[1] === 1'b1) hi++; else if (hi == 0) lo++;
                if (channel_interrupt[0] === 1'b1) n0++;
                if (channel_interrupt[1] === 1'b1) n1++;
            end
        join
        chk("os_delay", 32'(lo), 32'd9);
        chk("os_width", 32'(hi), 32'd3);
        chk("os_irq_m", 32'(n0), 32'd1);
        chk("os_irq_s", 32'(n1), 32'd1);
        rd(OFF_IRQ_ST, v); chk("os_status", v, 32'h3);
        wr(OFF_STOP, 32'h3);
    endtask
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf;
        err_total = 0; cmp_count = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_capture;
        t_pwm;
        t_oneshot;
        tally_and_finish;
    end
    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
